// file: core/cmp_control_page.sv
/*
  Control parameter page: select parsing, sense streaming, and the
  queue, allegiance, log and notification policies the page steers.
  Assumes the command layer frames one page per select and ends it with
  the last strobe, and that event inputs are one-cycle pulses.
*/
`timescale 1ns/1ns
module cmp_control_page #(
  parameter int CYCLES_PER_MS = cmp_pkg::CYCLES_PER_MS,
  parameter logic SAVABLE = 1'b0,
  parameter logic TAGGED_SUPPORTED = 1'b1,
  parameter logic [7:0] KEY_ILLEGAL_REQUEST = 8'h00,
  parameter logic [7:0] ASC_INVALID_FIELD = 8'h00,
  parameter logic [7:0] ASC_TAGS_CLEARED = 8'h00
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Select byte stream
  input wire logic sel_valid_i,
  input wire logic [7:0] sel_byte_i,
  input wire logic sel_last_i,
  output logic sel_done_o,
  output logic check_condition_o,
  output logic [7:0] sense_key_o,
  output logic [7:0] sense_asc_o,
  // Sense byte stream
  input wire logic sense_req_i,
  output logic sense_valid_o,
  output logic [7:0] sense_byte_o,
  output logic sense_last_o,
  // Queue and allegiance
  input wire logic ca_end_i,
  input wire logic [3:0] ca_owner_i,
  input wire logic [15:0] suspended_mask_i,
  input wire logic queue_tag_msg_i,
  output logic resume_suspended_o,
  output logic abort_suspended_o,
  output logic [15:0] ua_set_o,
  output logic [7:0] ua_asc_o,
  output logic tagged_enable_o,
  output logic abort_queued_o,
  output logic msg_reject_o,
  output logic run_untagged_o,
  output logic reorder_unrestricted_o,
  output logic [3:0] reorder_policy_o,
  output logic ext_allegiance_enable_o,
  // Log exceptions
  input wire logic log_exception_i,
  output logic log_exception_report_o,
  // Notification events
  input wire logic init_done_i,
  input wire logic unit_attn_event_i,
  input wire logic deferred_err_i,
  input wire logic aen_ack_i,
  output logic async_event_notice_o,
  output logic [2:0] aen_kind_o,
  output logic ua_raise_o,
  output logic defer_report_o
);

  function automatic logic [7:0] page_byte(input logic [2:0] idx, input logic [7:0] lg,
                                           input logic [7:0] qu, input logic [7:0] nt,
                                           input logic [15:0] ho);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      cmp_pkg::OFS_CODE: b = {SAVABLE, 1'b0, cmp_pkg::PAGE_CODE};
      cmp_pkg::OFS_LEN: b = cmp_pkg::PAGE_LEN;
      cmp_pkg::OFS_LOG: b = lg & cmp_pkg::MASK_LOG;
      cmp_pkg::OFS_QUEUE: b = qu & cmp_pkg::MASK_QUEUE;
      cmp_pkg::OFS_NOTIFY: b = nt & cmp_pkg::MASK_NOTIFY;
      cmp_pkg::OFS_HOLD_HI: b = ho[15:8];
      cmp_pkg::OFS_HOLD_LO: b = ho[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : page_byte

  ////////////////////////////////////////////////////////////////////////////
  // Select parsing and page storage.
  logic [3:0] sidx_q, sidx_d;
  logic serr_q, serr_d;
  logic [7:0] shd_q [8];
  logic [7:0] shd_d [8];
  logic [7:0] log_q, log_d, queue_q, queue_d, notify_q, notify_d;
  logic [15:0] holdoff_q, holdoff_d;
  logic sel_done_q, sel_done_d, chk_q, chk_d;
  logic bad;

  always_comb begin
    sidx_d = sidx_q;
    serr_d = serr_q;
    shd_d = shd_q;
    log_d = log_q;
    queue_d = queue_q;
    notify_d = notify_q;
    holdoff_d = holdoff_q;
    sel_done_d = 1'b0;
    chk_d = 1'b0;
    bad = serr_q;
    if (sel_valid_i) begin
      if (sidx_q < cmp_pkg::PAGE_BYTES) begin
        shd_d[sidx_q[2:0]] = sel_byte_i;
      end
      // Savable and reserved bits of byte 0 are ignored on select.
      bad = serr_q | (sidx_q >= cmp_pkg::PAGE_BYTES)
          | ((sidx_q == 4'h0) && (sel_byte_i[5:0] != cmp_pkg::PAGE_CODE))
          | ((sidx_q == 4'h1) && (sel_byte_i != cmp_pkg::PAGE_LEN));
      if (sel_last_i) begin
        if (!bad && (sidx_q == cmp_pkg::PAGE_BYTES - 4'h1)) begin
          log_d = shd_d[cmp_pkg::OFS_LOG] & cmp_pkg::MASK_LOG;
          queue_d = shd_d[cmp_pkg::OFS_QUEUE] & cmp_pkg::MASK_QUEUE;
          notify_d = shd_d[cmp_pkg::OFS_NOTIFY] & cmp_pkg::MASK_NOTIFY;
          holdoff_d = {shd_d[cmp_pkg::OFS_HOLD_HI], shd_d[cmp_pkg::OFS_HOLD_LO]};
          sel_done_d = 1'b1;
        end else begin
          chk_d = 1'b1;
        end
        sidx_d = 4'h0;
        serr_d = 1'b0;
      end else begin
        sidx_d = (sidx_q == 4'hF) ? sidx_q : sidx_q + 4'h1;
        serr_d = bad;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sidx_q <= 4'h0;
      serr_q <= 1'b0;
      shd_q <= '{default: 8'h00};
      log_q <= cmp_pkg::RST_LOG;
      queue_q <= cmp_pkg::RST_QUEUE;
      notify_q <= cmp_pkg::RST_NOTIFY;
      holdoff_q <= cmp_pkg::RST_HOLDOFF;
      sel_done_q <= 1'b0;
      chk_q <= 1'b0;
    end else begin
      sidx_q <= sidx_d;
      serr_q <= serr_d;
      shd_q <= shd_d;
      log_q <= log_d;
      queue_q <= queue_d;
      notify_q <= notify_d;
      holdoff_q <= holdoff_d;
      sel_done_q <= sel_done_d;
      chk_q <= chk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense streaming, one byte a cycle.
  cmp_pkg::cmp_sense_state_t sst_q, sst_d;
  logic [2:0] sptr_q, sptr_d, snum_q, snum_d;
  logic sv_q, sv_d, sl_q, sl_d;
  logic [7:0] sb_q, sb_d;

  always_comb begin
    sst_d = sst_q;
    sptr_d = sptr_q;
    snum_d = snum_q;
    sv_d = 1'b0;
    sl_d = 1'b0;
    sb_d = 8'h00;
    case (sst_q)
      cmp_pkg::SN_IDLE: begin
        if (sense_req_i) begin
          sst_d = cmp_pkg::SN_SEND;
          sptr_d = 3'h0;
        end
      end
      cmp_pkg::SN_SEND: begin
        sv_d = 1'b1;
        snum_d = sptr_q;
        sb_d = page_byte(sptr_q, log_q, queue_q, notify_q, holdoff_q);
        sl_d = (sptr_q == cmp_pkg::OFS_HOLD_LO);
        sptr_d = sptr_q + 3'h1;
        if (sl_d) begin
          sst_d = cmp_pkg::SN_IDLE;
        end
      end
      default: sst_d = cmp_pkg::SN_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sst_q <= cmp_pkg::SN_IDLE;
      sptr_q <= 3'h0;
      snum_q <= 3'h0;
      sv_q <= 1'b0;
      sl_q <= 1'b0;
      sb_q <= 8'h00;
    end else begin
      sst_q <= sst_d;
      sptr_q <= sptr_d;
      snum_q <= snum_d;
      sv_q <= sv_d;
      sl_q <= sl_d;
      sb_q <= sb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue, allegiance and log policy outputs.
  logic [15:0] owner_bit;
  logic res_d, abt_d, tqe_d, abq_d, rej_d, unr_d, extended_allegiance_enable_d, logr_d;
  logic res_q, abt_q, tqe_q, abq_q, rej_q, unr_q, extended_allegiance_enable_q, logr_q;
  logic [15:0] uas_d, uas_q;
  logic [3:0] pol_q;

  always_comb begin
    owner_bit = 16'h0001 << ca_owner_i;
    res_d = ca_end_i & ~queue_q[cmp_pkg::BIT_QUEUE_ERROR_ABORT_ABORT];
    abt_d = ca_end_i & queue_q[cmp_pkg::BIT_QUEUE_ERROR_ABORT_ABORT];
    uas_d = abt_d ? (suspended_mask_i & ~owner_bit) : 16'h0000;
    tqe_d = TAGGED_SUPPORTED & ~queue_q[cmp_pkg::BIT_DISABLE_TAGGED_QUEUING];
    // Abort queued work on the edge where queuing becomes disabled.
    abq_d = queue_d[cmp_pkg::BIT_DISABLE_TAGGED_QUEUING] & ~queue_q[cmp_pkg::BIT_DISABLE_TAGGED_QUEUING];
    rej_d = queue_tag_msg_i & queue_q[cmp_pkg::BIT_DISABLE_TAGGED_QUEUING];
    // Reserved and vendor codes fall back to the safe restricted order on reorder_unrestricted_o; reorder_policy_o passes the raw code.
    unr_d = (queue_q[cmp_pkg::QAM_MSB:cmp_pkg::QAM_LSB] == cmp_pkg::QAM_UNRESTRICTED);
    extended_allegiance_enable_d = notify_q[cmp_pkg::BIT_EXTENDED_ALLEGIANCE_ENABLE];
    logr_d = log_exception_i & log_q[cmp_pkg::BIT_LOG_REPORT];
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {res_q, abt_q, tqe_q, abq_q, rej_q, unr_q, extended_allegiance_enable_q, logr_q} <= 8'h00;
      uas_q <= 16'h0000;
      pol_q <= cmp_pkg::QAM_RESTRICTED;
    end else begin
      {res_q, abt_q, tqe_q, abq_q, rej_q, unr_q, extended_allegiance_enable_q, logr_q} <=
          {res_d, abt_d, tqe_d, abq_d, rej_d, unr_d, extended_allegiance_enable_d, logr_d};
      uas_q <= uas_d;
      pol_q <= queue_q[cmp_pkg::QAM_MSB:cmp_pkg::QAM_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous event notification.
  logic holdoff_met;
  logic [2:0] pend_q, pend_d, kind_q, kind_d, ev, permit;
  logic req_q, req_d, uar_q, uar_d, dfr_q, dfr_d;

  cmp_holdoff_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_holdoff (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .holdoff_i(holdoff_q),
    .holdoff_met_o(holdoff_met)
  );

  // Bit 2 ready, bit 1 unit attention, bit 0 deferred error.
  always_comb begin
    ev = {init_done_i, unit_attn_event_i, deferred_err_i};
    permit = {notify_q[cmp_pkg::BIT_READY_PERMIT], notify_q[cmp_pkg::BIT_ATTN_PERMIT],
              notify_q[cmp_pkg::BIT_ERR_PERMIT]};
    pend_d = pend_q;
    kind_d = kind_q;
    req_d = req_q & ~aen_ack_i;
    // A pending notice whose permit was withdrawn falls back to the normal path.
    uar_d = |((ev[2:1] | pend_q[2:1]) & ~permit[2:1]);
    dfr_d = (ev[0] | pend_q[0]) & ~permit[0];
    pend_d = pend_q & permit;
    if (!req_q && holdoff_met) begin
      if (pend_d[2]) begin
        kind_d = 3'h4;
      end else if (pend_d[1]) begin
        kind_d = 3'h2;
      end else begin
        kind_d = 3'h1;
      end
      if (pend_d != 3'h0) begin
        req_d = 1'b1;
        pend_d = pend_d & ~kind_d;
      end
    end
    // A new event in the same cycle as its issue stays pending.
    pend_d = pend_d | (ev & permit);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= 3'h0;
      kind_q <= 3'h0;
      req_q <= 1'b0;
      uar_q <= 1'b0;
      dfr_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      kind_q <= kind_d;
      req_q <= req_d;
      uar_q <= uar_d;
      dfr_q <= dfr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from flip-flops, except ua_asc_o, a constant, and the sense codes, which chk_q gates.
  assign sel_done_o = sel_done_q;
  assign check_condition_o = chk_q;
  assign sense_key_o = chk_q ? KEY_ILLEGAL_REQUEST : 8'h00;
  assign sense_asc_o = chk_q ? ASC_INVALID_FIELD : 8'h00;
  assign sense_valid_o = sv_q;
  assign sense_byte_o = sb_q;
  assign sense_last_o = sl_q;
  assign resume_suspended_o = res_q;
  assign abort_suspended_o = abt_q;
  assign ua_set_o = uas_q;
  assign ua_asc_o = ASC_TAGS_CLEARED;
  assign tagged_enable_o = tqe_q;
  assign abort_queued_o = abq_q;
  assign msg_reject_o = rej_q;
  assign run_untagged_o = rej_q;
  assign reorder_unrestricted_o = unr_q;
  assign reorder_policy_o = pol_q;
  assign ext_allegiance_enable_o = extended_allegiance_enable_q;
  assign log_exception_report_o = logr_q;
  assign async_event_notice_o = req_q;
  assign aen_kind_o = kind_q;
  assign ua_raise_o = uar_q;
  assign defer_report_o = dfr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_hdr;
    (sense_byte_o[5:0] == cmp_pkg::PAGE_CODE) ##1 (sense_byte_o == cmp_pkg::PAGE_LEN);
  endsequence
  sequence s_eight;
    (sense_valid_o && !sense_last_o) [*7] ##1 (sense_valid_o && sense_last_o);
  endsequence

  a_sense_header: assert property ($rose(sense_valid_o) |-> s_hdr)
    else $error("sense header wrong");
  a_sense_length: assert property ($rose(sense_valid_o) |-> s_eight)
    else $error("sense stream not eight bytes");
  a_log_gate: assert property (log_exception_i |=> log_exception_report_o == $past(log_q[0]))
    else $error("log report gating wrong");
  a_reorder_code: assert property (##1 reorder_unrestricted_o == ($past(queue_q[7:4]) == 4'h1))
    else $error("reorder policy wrong");
  a_queue_error_abort_abort: assert property (ca_end_i && queue_q[1] |=> abort_suspended_o && !resume_suspended_o
      && ua_set_o == ($past(suspended_mask_i) & ~(16'h0001 << $past(ca_owner_i))))
    else $error("abort or unit attention wrong");
  a_queue_error_abort_resume: assert property (ca_end_i && !queue_q[1] |=> resume_suspended_o
      && ua_set_o == 16'h0000)
    else $error("resume wrong");
  a_tag_reject: assert property (queue_tag_msg_i && queue_q[0] |=> msg_reject_o && run_untagged_o)
    else $error("tag not rejected");
  a_no_notice: assert property (notify_q[2:0] == 3'h0 && !async_event_notice_o
      |=> !async_event_notice_o)
    else $error("notice while permits clear");
  a_holdoff_wait: assert property ($rose(async_event_notice_o) |-> $past(holdoff_met))
    else $error("notice before holdoff");
  a_check_keeps: assert property (check_condition_o |-> $stable(log_q) && $stable(queue_q)
      && $stable(notify_q) && $stable(holdoff_q))
    else $error("bad page changed settings");
  a_rsvd_zero: assert property (sense_valid_o && snum_q == cmp_pkg::OFS_RSVD
      |-> sense_byte_o == 8'h00)
    else $error("reserved byte not zero");

endmodule : cmp_control_page

// file: core/cmp_pkg.sv
/*
  Constants for the control parameter page handler: page layout, field
  positions, write masks, reset values and timing counts.
  Assumes a 20 MHz target clock and a page byte stream already framed
  by the command layer.
*/
package cmp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Page layout.
  localparam logic [5:0] PAGE_CODE = 6'h0A;
  localparam logic [7:0] PAGE_LEN = 8'h06;
  localparam logic [3:0] PAGE_BYTES = 4'h8;
  localparam logic [2:0] OFS_CODE = 3'h0;
  localparam logic [2:0] OFS_LEN = 3'h1;
  localparam logic [2:0] OFS_LOG = 3'h2;
  localparam logic [2:0] OFS_QUEUE = 3'h3;
  localparam logic [2:0] OFS_NOTIFY = 3'h4;
  localparam logic [2:0] OFS_RSVD = 3'h5;
  localparam logic [2:0] OFS_HOLD_HI = 3'h6;
  localparam logic [2:0] OFS_HOLD_LO = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int BIT_SAVABLE = 7;
  localparam int BIT_LOG_REPORT = 0;
  localparam int BIT_QUEUE_ERROR_ABORT_ABORT = 1;
  localparam int BIT_DISABLE_TAGGED_QUEUING = 0;
  localparam int BIT_EXTENDED_ALLEGIANCE_ENABLE = 7;
  localparam int BIT_READY_PERMIT = 2;
  localparam int BIT_ATTN_PERMIT = 1;
  localparam int BIT_ERR_PERMIT = 0;
  localparam int QAM_MSB = 7;
  localparam int QAM_LSB = 4;
  localparam logic [3:0] QAM_RESTRICTED = 4'h0;
  localparam logic [3:0] QAM_UNRESTRICTED = 4'h1;

  // Writable bits of each byte; everything else is reserved.
  localparam logic [7:0] MASK_LOG = 8'h01;
  localparam logic [7:0] MASK_QUEUE = 8'hF3;
  localparam logic [7:0] MASK_NOTIFY = 8'h87;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_LOG = 8'h00;
  localparam logic [7:0] RST_QUEUE = 8'h00;
  localparam logic [7:0] RST_NOTIFY = 8'h00;
  localparam logic [15:0] RST_HOLDOFF = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    SN_IDLE,
    SN_SEND
  } cmp_sense_state_t;

endpackage : cmp_pkg

// file: core/cmp_holdoff_timer.sv
/*
  Millisecond tick divider and elapsed-millisecond counter for the
  notification holdoff.
  Assumes the count starts at reset release, which is taken as the start
  of initialization.
*/
`timescale 1ns/1ns
module cmp_holdoff_timer #(
  parameter int CYCLES_PER_MS = cmp_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Programmed holdoff in milliseconds
  input wire logic [15:0] holdoff_i,
  // Holdoff has elapsed
  output logic holdoff_met_o
);

  localparam logic [15:0] DIV_LAST = 16'(CYCLES_PER_MS - 1);

  logic [15:0] div_q, div_d;
  logic [15:0] ms_q, ms_d;
  logic met_q, met_d;

  // A partial millisecond is never counted, so the wait rounds up.
  always_comb begin
    div_d = div_q;
    ms_d = ms_q;
    if (div_q == DIV_LAST) begin
      div_d = 16'h0000;
      if (ms_q != 16'hFFFF) begin
        ms_d = ms_q + 16'h0001;
      end
    end else begin
      div_d = div_q + 16'h0001;
    end
    met_d = (ms_q >= holdoff_i);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 16'h0000;
      ms_q <= 16'h0000;
      met_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ms_q <= ms_d;
      met_q <= met_d;
    end
  end

  assign holdoff_met_o = met_q;

endmodule : cmp_holdoff_timer

// file: verification/cmp_initiator_model.sv
/*
  Initiator model: frames select pages and collects sense pages.
  Assumes the page handler's select and sense byte streams on one clock.
*/
`timescale 1ns/1ns
module cmp_initiator_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Select stream
  output logic sel_valid_o,
  output logic [7:0] sel_byte_o,
  output logic sel_last_o,
  // Sense stream
  output logic sense_req_o,
  input wire logic sense_valid_i,
  input wire logic [7:0] sense_byte_i,
  input wire logic sense_last_i
);
  initial begin
    sel_valid_o = 1'b0;
    sel_byte_o = 8'h00;
    sel_last_o = 1'b0;
    sense_req_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sends the first n bytes of pg, top byte first; n other than 8 is a fault.
  task automatic send_page(input logic [63:0] pg, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      sel_valid_o <= 1'b1;
      sel_byte_o <= pg[63-8*i -: 8];
      sel_last_o <= (i == n - 1);
    end
    @(posedge clock_i);
    sel_valid_o <= 1'b0;
    sel_last_o <= 1'b0;
    // A released lane shows the inverse, so stale data cannot pass for new.
    sel_byte_o <= ~sel_byte_o;
  endtask : send_page

  task automatic read_page(output logic [63:0] pg, output int n);
    pg = 64'h0000_0000_0000_0000;
    n = 0;
    @(posedge clock_i);
    sense_req_o <= 1'b1;
    @(posedge clock_i);
    sense_req_o <= 1'b0;
    // Bytes are taken mid-cycle, where the handler's outputs have settled.
    for (int c = 0; c < 12; c++) begin
      @(negedge clock_i);
      if (sense_valid_i === 1'b1) begin
        pg = {pg[55:0], sense_byte_i};
        n++;
        if (sense_last_i === 1'b1) break;
      end
    end
  endtask : read_page
endmodule : cmp_initiator_model

// file: verification/cmp_control_page_tb.sv
/*
  Self-checking bench for the control page handler.
  Assumes the initiator model drives the select and sense streams.
*/
`timescale 1ns/1ns
module cmp_control_page_tb;
  // Sense codes are arbitrary values, chosen only to be distinct.
  localparam logic [7:0] KEY = 8'hA1;
  localparam logic [7:0] ASC_BAD = 8'hB2;
  localparam logic [7:0] ASC_CLR = 8'hC3;

  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [6:0] evs = 7'h00;
  logic ca_end_i, queue_tag_msg_i, log_exception_i, init_done_i;
  logic unit_attn_event_i, deferred_err_i, aen_ack_i;
  logic sel_valid_i, sel_last_i, sense_req_i;
  logic [7:0] sel_byte_i;
  logic [3:0] ca_owner_i = 4'h3;
  logic [15:0] suspended_mask_i = 16'h000F;
  logic sel_done_o, check_condition_o, sense_valid_o, sense_last_o;
  logic resume_suspended_o, abort_suspended_o, tagged_enable_o, abort_queued_o;
  logic msg_reject_o, run_untagged_o, reorder_unrestricted_o, ext_allegiance_enable_o;
  logic log_exception_report_o, async_event_notice_o, ua_raise_o, defer_report_o;
  logic [7:0] sense_key_o, sense_asc_o, sense_byte_o, ua_asc_o;
  logic [15:0] ua_set_o;
  logic [3:0] reorder_policy_o;
  logic [2:0] aen_kind_o;
  int fail_count = 0;
  int total_checks = 0;
  logic [63:0] pg;
  int n;

  assign {ca_end_i, queue_tag_msg_i, log_exception_i, init_done_i} = evs[6:3];
  assign {unit_attn_event_i, deferred_err_i, aen_ack_i} = evs[2:0];

  always #25 clock_i = ~clock_i;

  cmp_control_page #(
    .CYCLES_PER_MS(4), .KEY_ILLEGAL_REQUEST(KEY), .ASC_INVALID_FIELD(ASC_BAD),
    .ASC_TAGS_CLEARED(ASC_CLR)
  ) i_cmp_control_page (
    .clock_i, .arst_n_i, .sel_valid_i, .sel_byte_i, .sel_last_i, .sel_done_o,
    .check_condition_o, .sense_key_o, .sense_asc_o, .sense_req_i, .sense_valid_o,
    .sense_byte_o, .sense_last_o, .ca_end_i, .ca_owner_i, .suspended_mask_i,
    .queue_tag_msg_i, .resume_suspended_o, .abort_suspended_o, .ua_set_o, .ua_asc_o,
    .tagged_enable_o, .abort_queued_o, .msg_reject_o, .run_untagged_o,
    .reorder_unrestricted_o, .reorder_policy_o, .ext_allegiance_enable_o,
    .log_exception_i, .log_exception_report_o, .init_done_i, .unit_attn_event_i,
    .deferred_err_i, .aen_ack_i, .async_event_notice_o, .aen_kind_o, .ua_raise_o,
    .defer_report_o
  );

  cmp_initiator_model i_cmp_initiator_model (
    .clock_i, .arst_n_i, .sel_valid_o(sel_valid_i), .sel_byte_o(sel_byte_i),
    .sel_last_o(sel_last_i), .sense_req_o(sense_req_i), .sense_valid_i(sense_valid_o),
    .sense_byte_i(sense_byte_o), .sense_last_i(sense_last_o)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic put(input logic [63:0] p, input int len, input logic ok);
    i_cmp_initiator_model.send_page(p, len);
    @(negedge clock_i);
    chk(sel_done_o, ok);
    chk(check_condition_o, !ok);
    chk({sense_key_o, sense_asc_o}, ok ? 16'h0000 : {KEY, ASC_BAD});
  endtask : put

  task automatic get(input logic [63:0] exp);
    i_cmp_initiator_model.read_page(pg, n);
    chk(n, 8);
    chk(pg, exp);
  endtask : get

  // Pulses event inputs for one cycle; returns where the answer is settled.
  task automatic ev(input logic [6:0] v);
    @(posedge clock_i);
    evs <= v;
    @(posedge clock_i);
    evs <= 7'h00;
    @(negedge clock_i);
  endtask : ev

  task automatic notice(input logic [2:0] kind);
    for (int c = 0; c < 8 && async_event_notice_o !== 1'b1; c++) @(negedge clock_i);
    chk(async_event_notice_o, 1'b1);
    chk(aen_kind_o, kind);
    ev(7'h01);
    chk(async_event_notice_o, 1'b0);
  endtask : notice

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clock_i);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    chk({tagged_enable_o, ua_asc_o}, {1'b1, ASC_CLR});
    chk({reorder_unrestricted_o, reorder_policy_o}, 5'h00);
    get(64'h0A06_0000_0000_0000);
    $display("test reset done");

    put(64'h8A06_FFFF_FFFF_FFFF, 8, 1'b1);
    // The queued-work abort rides with the commit pulse and is gone one cycle later.
    chk(abort_queued_o, 1'b1);
    @(negedge clock_i);
    chk({abort_queued_o, tagged_enable_o}, 2'b00);
    chk(ext_allegiance_enable_o, 1'b1);
    chk({reorder_unrestricted_o, reorder_policy_o}, 5'h0F);
    get(64'h0A06_01F3_8700_FFFF);
    ev(7'h40);
    chk({abort_suspended_o, resume_suspended_o, ua_set_o}, {2'b10, 16'h0007});
    ev(7'h20);
    chk({msg_reject_o, run_untagged_o}, 2'b11);
    ev(7'h10);
    chk(log_exception_report_o, 1'b1);
    ev(7'h08);
    repeat (20) @(negedge clock_i);
    chk(async_event_notice_o, 1'b0);
    $display("test set all done");

    put(64'h0A06_0010_0700_0000, 8, 1'b1);
    notice(3'b100);
    chk({tagged_enable_o, reorder_unrestricted_o}, 2'b11);
    chk(ext_allegiance_enable_o, 1'b0);
    ev(7'h40);
    chk({abort_suspended_o, resume_suspended_o, ua_set_o}, {2'b01, 16'h0000});
    ev(7'h20);
    chk({msg_reject_o, run_untagged_o}, 2'b00);
    ev(7'h10);
    chk(log_exception_report_o, 1'b0);
    for (int k = 0; k < 3; k++) begin
      ev(7'h08 >> k);
      notice(3'b100 >> k);
    end
    $display("test notices done");

    put(64'h0A06_0080_0000_0000, 8, 1'b1);
    @(negedge clock_i);
    chk({reorder_unrestricted_o, reorder_policy_o}, 5'h08);
    for (int k = 0; k < 3; k++) begin
      ev(7'h08 >> k);
      chk({async_event_notice_o, ua_raise_o, defer_report_o}, {1'b0, k < 2, k == 2});
    end
    $display("test no permits done");

    put(64'h0A07_0000_0000_0000, 8, 1'b0);
    put(64'h0B06_0111_8700_0000, 8, 1'b0);
    put(64'h0A06_0111_8700_0000, 6, 1'b0);
    get(64'h0A06_0080_0000_0000);
    $display("test refusals done");
    end_sim();
  end
endmodule : cmp_control_page_tb
